// [hw/line_step_engine.sv]
// Line and step-vector draw sequencer with map pointer stepping
`timescale 1ns/1ps
`include "line_step_cfg.svh"
module line_step_engine (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic opWrite,
  input wire logic [`FN_W-1:0] opFunction,
  input wire logic [2:0] opOctant,
  input wire logic [1:0] opDrawMode,
  input wire logic opReadDraw,
  input wire logic [`DIM_W-1:0] opLength,
  input wire line_step_pkg::err_t errInit,
  input wire line_step_pkg::err_t k1Init,
  input wire line_step_pkg::err_t k2Init,
  input wire logic stepWrite,
  input wire logic [31:0] stepData,
  input wire logic [3:0] stepByteEn,
  input wire logic ptrLoad,
  input wire line_step_pkg::ptr_t srcXInit,
  input wire line_step_pkg::ptr_t srcYInit,
  input wire line_step_pkg::ptr_t patXInit,
  input wire line_step_pkg::ptr_t patYInit,
  input wire line_step_pkg::ptr_t dstXInit,
  input wire line_step_pkg::ptr_t dstYInit,
  input wire logic [`DIM_W-1:0] srcWidth,
  input wire logic [`DIM_W-1:0] srcHeight,
  input wire logic [`DIM_W-1:0] patWidth,
  input wire logic [`DIM_W-1:0] patHeight,
  input wire logic [`DIM_W-1:0] dstWidth,
  input wire logic [`DIM_W-1:0] dstHeight,
  output logic busy,
  output logic pixValid,
  output logic pixWrite,
  output line_step_pkg::ptr_t pixSrcX,
  output line_step_pkg::ptr_t pixSrcY,
  output line_step_pkg::ptr_t pixPatX,
  output line_step_pkg::ptr_t pixPatY,
  output line_step_pkg::ptr_t pixDstX,
  output line_step_pkg::ptr_t pixDstY,
  output line_step_pkg::ptr_t srcX,
  output line_step_pkg::ptr_t srcY,
  output line_step_pkg::ptr_t patX,
  output line_step_pkg::ptr_t patY,
  output line_step_pkg::ptr_t dstX,
  output line_step_pkg::ptr_t dstY
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] codeAt(input logic [31:0] codes,
                                        input logic [1:0] idx);
    codeAt = codes[{idx, 3'b000} +: 8];
  endfunction : codeAt

  function automatic logic [3:0] codeCount(input logic [31:0] codes,
                                           input logic [1:0] idx);
    codeCount = codes[{idx, 3'b000} +: (`CODE_CNT_MSB + 1)];
  endfunction : codeCount

  function automatic logic [1:0] lowestByte(input logic [3:0] en);
    lowestByte = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (en[i]) begin
        lowestByte = 2'(i);
      end
    end
  endfunction : lowestByte

  ////////////////////////////////////////////////////////////////////////////
  // State

  line_step_pkg::engine_state_t state_reg, state_next;
  logic [`FN_W-1:0] func_reg, func_next;
  logic [2:0] octant_reg, octant_next;
  logic [1:0] mode_reg, mode_next;
  logic readDraw_reg, readDraw_next;
  line_step_pkg::err_t err_reg, err_next;
  line_step_pkg::err_t k1_reg, k1_next;
  line_step_pkg::err_t k2_reg, k2_next;
  logic [`DIM_W-1:0] remain_reg, remain_next;
  logic [31:0] codes_reg, codes_next;
  logic [1:0] idx_reg, idx_next;
  logic first_reg, first_next;
  logic prevYChg_reg, prevYChg_next;
  line_step_pkg::ptr_t srcX_reg, srcX_next, srcY_reg, srcY_next;
  line_step_pkg::ptr_t patX_reg, patX_next, patY_reg, patY_next;
  line_step_pkg::ptr_t dstX_reg, dstX_next, dstY_reg, dstY_next;
  logic busy_reg, busy_next;
  logic pixValid_reg, pixValid_next;
  logic pixWrite_reg, pixWrite_next;
  line_step_pkg::ptr_t pixSrcX_reg, pixSrcX_next, pixSrcY_reg, pixSrcY_next;
  line_step_pkg::ptr_t pixPatX_reg, pixPatX_next, pixPatY_reg, pixPatY_next;
  line_step_pkg::ptr_t pixDstX_reg, pixDstX_next, pixDstY_reg, pixDstY_next;

  ////////////////////////////////////////////////////////////////////////////
  // Step decode and pointer wrapping

  logic [7:0] curCode;
  logic isStep;
  logic signed [1:0] fdx, fdy;
  logic signed [1:0] srcDx, srcDy, dstDx, dstDy;
  line_step_pkg::err_t errStep;
  logic horiz, down;
  line_step_pkg::ptr_t srcXw, srcYw, patXw, patYw;

  assign curCode = codeAt(codes_reg, idx_reg);
  assign isStep = (state_reg == line_step_pkg::ST_STEP);

  step_decode u_decode (
    .isStep(isStep),
    .dir(curCode[`CODE_DIR_MSB:`CODE_DIR_LSB]),
    .octant(octant_reg),
    .err(err_reg),
    .k1(k1_reg),
    .k2(k2_reg),
    .dx(fdx),
    .dy(fdy),
    .errNext(errStep),
    .horiz(horiz),
    .down(down)
  );

  map_wrap u_srcx (.pos(srcX_reg), .delta(srcDx), .extent(srcWidth),
                   .next(srcXw)); // RULE_15
  map_wrap u_srcy (.pos(srcY_reg), .delta(srcDy), .extent(srcHeight),
                   .next(srcYw));
  map_wrap u_patx (.pos(patX_reg), .delta(srcDx), .extent(patWidth),
                   .next(patXw)); // RULE_14
  map_wrap u_paty (.pos(patY_reg), .delta(srcDy), .extent(patHeight),
                   .next(patYw));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic isLast, drawEn, yInside, xInside, leftClip, stepDone;

  always_comb begin
    state_next = state_reg;
    func_next = func_reg;
    octant_next = octant_reg;
    mode_next = mode_reg;
    readDraw_next = readDraw_reg;
    err_next = err_reg;
    k1_next = k1_reg;
    k2_next = k2_reg;
    remain_next = remain_reg;
    codes_next = codes_reg;
    idx_next = idx_reg;
    first_next = first_reg;
    prevYChg_next = prevYChg_reg;
    srcX_next = srcX_reg;
    srcY_next = srcY_reg;
    patX_next = patX_reg;
    patY_next = patY_reg;
    dstX_next = dstX_reg;
    dstY_next = dstY_reg;
    busy_next = busy_reg;
    pixValid_next = 1'b0;
    pixWrite_next = 1'b0;
    pixSrcX_next = pixSrcX_reg;
    pixSrcY_next = pixSrcY_reg;
    pixPatX_next = pixPatX_reg;
    pixPatY_next = pixPatY_reg;
    pixDstX_next = pixDstX_reg;
    pixDstY_next = pixDstY_reg;
    isLast = (remain_reg == '0);
    drawEn = 1'b0;
    yInside = (dstY_reg >= 0) && (dstY_reg < `PTR_W'(dstHeight));
    xInside = (dstX_reg >= 0) && (dstX_reg < `PTR_W'(dstWidth));
    leftClip = 1'b0;
    stepDone = 1'b0;
    // The function-driven map moves only between pixels; passive x always
    srcDx = readDraw_reg ? (isLast ? 2'sd0 : fdx) : 2'sd1; // RULE_12 RULE_13
    srcDy = (readDraw_reg && !isLast) ? fdy : 2'sd0; // RULE_13
    dstDx = readDraw_reg ? 2'sd1 : (isLast ? 2'sd0 : fdx); // RULE_11 RULE_13
    dstDy = (!readDraw_reg && !isLast) ? fdy : 2'sd0; // RULE_11

    case (state_reg)
      line_step_pkg::ST_IDLE: begin
        if (ptrLoad) begin
          srcX_next = srcXInit;
          srcY_next = srcYInit;
          patX_next = patXInit;
          patY_next = patYInit;
          dstX_next = dstXInit;
          dstY_next = dstYInit;
        end
        if (opWrite) begin
          func_next = opFunction;
          octant_next = opOctant;
          mode_next = opDrawMode;
          readDraw_next = opReadDraw;
          err_next = errInit; // RULE_09
          k1_next = k1Init;
          k2_next = k2Init;
          // Only the line function starts here; step function waits
          if (opFunction == `FN_LINE) begin // RULE_01
            state_next = line_step_pkg::ST_LINE;
            remain_next = opLength;
            first_next = 1'b1;
            prevYChg_next = 1'b0;
            busy_next = 1'b1;
          end
        end else if (stepWrite && stepByteEn[`TOP_BYTE] &&
                     func_reg == `FN_STEP) begin // RULE_02 RULE_24
          codes_next = stepData;
          idx_next = lowestByte(stepByteEn); // RULE_05
          remain_next = `DIM_W'(codeCount(stepData,
            lowestByte(stepByteEn))); // RULE_22
          first_next = 1'b1;
          prevYChg_next = 1'b0;
          state_next = line_step_pkg::ST_STEP;
          busy_next = 1'b1;
        end
      end
      line_step_pkg::ST_LINE, line_step_pkg::ST_STEP: begin
        // Endpoint suppression and area rules per code or line
        case (mode_reg) // RULE_17 RULE_25
          `MODE_FIRST_NULL: drawEn = !first_reg;
          `MODE_LAST_NULL: drawEn = !isLast;
          `MODE_AREA: begin // RULE_18
            if (horiz) begin
              drawEn = 1'b0;
            end else if (down) begin
              drawEn = !isLast && (fdy != 2'sd0);
            end else begin
              drawEn = !first_reg && prevYChg_reg;
            end
          end
          default: drawEn = 1'b1;
        endcase
        if (isStep && !curCode[`CODE_DRAW_BIT]) begin
          drawEn = 1'b0; // RULE_23
        end
        // Outline clipped on the left still marks the fill start
        leftClip = (mode_reg == `MODE_AREA) && (dstX_reg < 0) &&
                   yInside; // RULE_20
        pixValid_next = 1'b1;
        pixWrite_next = drawEn && yInside && (xInside || leftClip); // RULE_15
        pixSrcX_next = srcX_reg;
        pixSrcY_next = srcY_reg;
        pixPatX_next = patX_reg;
        pixPatY_next = patY_reg;
        pixDstX_next = leftClip ? '0 : dstX_reg;
        pixDstY_next = dstY_reg;
        // Destination keeps stepping off-map; only writes are inhibited
        srcX_next = srcXw;
        srcY_next = srcYw;
        patX_next = patXw;
        patY_next = patYw;
        dstX_next = dstX_reg + `PTR_W'(dstDx);
        dstY_next = dstY_reg + `PTR_W'(dstDy);
        prevYChg_next = (fdy != 2'sd0);
        first_next = 1'b0;
        remain_next = remain_reg - `DIM_W'(1);
        if (!isStep && !isLast) begin
          err_next = errStep; // RULE_26
        end
        if (isLast) begin // RULE_10
          if (!isStep) begin
            stepDone = 1'b1;
          end else if (curCode == `STOP_CODE || idx_reg == 2'h3) begin
            stepDone = 1'b1; // RULE_03
          end else begin
            idx_next = idx_reg + 2'h1; // RULE_24
            remain_next = `DIM_W'(codeCount(codes_reg, idx_reg + 2'h1));
            first_next = 1'b1;
            prevYChg_next = 1'b0;
          end
        end
        if (stepDone) begin
          state_next = line_step_pkg::ST_IDLE;
          busy_next = 1'b0; // RULE_04
        end
      end
      default: begin
        state_next = line_step_pkg::ST_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= line_step_pkg::ST_IDLE;
      mode_reg <= `MODE_NORMAL;
      {func_reg, octant_reg, readDraw_reg, idx_reg} <= '0;
      {err_reg, k1_reg, k2_reg, remain_reg, codes_reg} <= '0;
      {first_reg, prevYChg_reg, busy_reg, pixValid_reg, pixWrite_reg} <= '0;
      {srcX_reg, srcY_reg, patX_reg, patY_reg, dstX_reg, dstY_reg} <= '0;
      {pixSrcX_reg, pixSrcY_reg, pixPatX_reg, pixPatY_reg} <= '0;
      {pixDstX_reg, pixDstY_reg} <= '0;
    end else begin
      state_reg <= state_next;
      func_reg <= func_next;
      octant_reg <= octant_next;
      mode_reg <= mode_next;
      readDraw_reg <= readDraw_next;
      err_reg <= err_next;
      k1_reg <= k1_next;
      k2_reg <= k2_next;
      remain_reg <= remain_next;
      codes_reg <= codes_next;
      idx_reg <= idx_next;
      first_reg <= first_next;
      prevYChg_reg <= prevYChg_next;
      srcX_reg <= srcX_next;
      srcY_reg <= srcY_next;
      patX_reg <= patX_next;
      patY_reg <= patY_next;
      dstX_reg <= dstX_next;
      dstY_reg <= dstY_next;
      busy_reg <= busy_next;
      pixValid_reg <= pixValid_next;
      pixWrite_reg <= pixWrite_next;
      pixSrcX_reg <= pixSrcX_next;
      pixSrcY_reg <= pixSrcY_next;
      pixPatX_reg <= pixPatX_next;
      pixPatY_reg <= pixPatY_next;
      pixDstX_reg <= pixDstX_next;
      pixDstY_reg <= pixDstY_next;
    end
  end

  assign {busy, pixValid, pixWrite} = {busy_reg, pixValid_reg, pixWrite_reg};
  assign {pixSrcX, pixSrcY, pixPatX} = {pixSrcX_reg, pixSrcY_reg, pixPatX_reg};
  assign {pixPatY, pixDstX, pixDstY} = {pixPatY_reg, pixDstX_reg, pixDstY_reg};
  assign {srcX, srcY, patX} = {srcX_reg, srcY_reg, patX_reg};
  assign {patY, dstX, dstY} = {patY_reg, dstX_reg, dstY_reg};

endmodule : line_step_engine

// [common/line_step_cfg.svh]
// Constants for the line and step-vector draw engine
// Summary of operation
// RULE_01: Function is selected first; selecting step-vector function alone never starts drawing.
// RULE_02: Step register write with any other function selected does nothing.
// RULE_03: Code 00 is executed, then ends the operation; later codes ignored.
// RULE_04: Completion, also by stop code, drops the busy indication.
// RULE_05: Fewer than four codes: stop code after them, or write upper bytes only.
// RULE_06: Line stepper works in octant zero; octant is {x sign, y sign, major}.
// RULE_07: Sign flags are 1 for negative; major flag 1 when |x| <= |y|.
// RULE_08: Software loads the line length, the major delta, before starting.
// RULE_09: Stepper takes initial error, first constant and second constant.
// RULE_10: After a line the pointers address its final pixel; the passive map x pointer is left one step past it.
// RULE_11: Write draw: destination follows the function, source steps in x only.
// RULE_12: Read draw: source follows the function, destination steps in x only.
// RULE_13: Passive map always increments x and never changes y.
// RULE_14: Pattern steps like source; mask steps like destination.
// RULE_15: Source and pattern wrap at map edges; destination writes are scissored.
// RULE_16: Fixed colour lines need write draw, chosen by software.
// RULE_17: Modes suppress first or last pixel for lines and step vectors.
// RULE_18: Area mode: down keeps run ends, up keeps run starts, horizontal draws none.
// RULE_19: Outline drawing uses area mode and exclusive-or mix.
// RULE_20: Outline clipped at the left map edge still writes a pixel there.
// RULE_21: Software disables mask scissoring for outlines, restores it for fill.
// RULE_22: Code byte: 3-bit direction, move or draw flag, count; count+1 pixels.
// RULE_23: Move flag 0 only moves pointers; 1 draws pixels.
// RULE_24: Top byte write starts; codes run from lowest byte upward.
// RULE_25: For endpoint suppression every step code is its own line.
// RULE_26: Each step advances major axis; non-negative error also minor and K2.
`ifndef LINE_STEP_CFG_SVH
`define LINE_STEP_CFG_SVH
`define PTR_W 13
`define DIM_W 12
`define ERR_W 16
`define FN_W 3
`define FN_STEP 3'h1
`define FN_LINE 3'h2
`define MODE_NORMAL 2'h0
`define MODE_FIRST_NULL 2'h1
`define MODE_LAST_NULL 2'h2
`define MODE_AREA 2'h3
`define OCT_XSIGN 2
`define OCT_YSIGN 1
`define OCT_MAJOR 0
`define CODE_DIR_MSB 7
`define CODE_DIR_LSB 5
`define CODE_DRAW_BIT 4
`define CODE_CNT_MSB 3
`define STOP_CODE 8'h00
`define TOP_BYTE 3
`endif

// [common/line_step_pkg.sv]
// Types shared by the draw engine files
`include "line_step_cfg.svh"
package line_step_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_LINE, ST_STEP} engine_state_t;
  typedef logic signed [`PTR_W-1:0] ptr_t;
  typedef logic signed [`ERR_W-1:0] err_t;
endpackage : line_step_pkg

// [hw/map_wrap.sv]
// Next pointer on one axis, wrapped inside the map extent
`timescale 1ns/1ps
`include "line_step_cfg.svh"
module map_wrap (
  input wire line_step_pkg::ptr_t pos,
  input wire logic signed [1:0] delta,
  input wire logic [`DIM_W-1:0] extent,
  output line_step_pkg::ptr_t next
);
  line_step_pkg::ptr_t sum;
  line_step_pkg::ptr_t top;
  always_comb begin
    sum = pos + `PTR_W'(delta);
    top = `PTR_W'(extent);
    if (sum < 0) begin
      next = top - `PTR_W'(1);
    end else if (sum >= top) begin
      next = '0;
    end else begin
      next = sum;
    end
  end
endmodule : map_wrap

// [hw/step_decode.sv]
// Per-pixel step direction and error update for line and step codes
`timescale 1ns/1ps
`include "line_step_cfg.svh"
module step_decode (
  input wire logic isStep,
  input wire logic [2:0] dir,
  input wire logic [2:0] octant,
  input wire line_step_pkg::err_t err,
  input wire line_step_pkg::err_t k1,
  input wire line_step_pkg::err_t k2,
  output logic signed [1:0] dx,
  output logic signed [1:0] dy,
  output line_step_pkg::err_t errNext,
  output logic horiz,
  output logic down
);
  logic signed [1:0] sx;
  logic signed [1:0] sy;
  logic minorStep;
  always_comb begin
    sx = octant[`OCT_XSIGN] ? -2'sd1 : 2'sd1;
    sy = octant[`OCT_YSIGN] ? -2'sd1 : 2'sd1;
    minorStep = (err >= 0);
    errNext = minorStep ? err + k2 : err + k1; // RULE_26
    dx = 2'sd0;
    dy = 2'sd0;
    if (isStep) begin
      // Direction n points n*45 degrees anticlockwise from +x, y down
      case (dir) // RULE_22
        3'h0: begin dx = 2'sd1; dy = 2'sd0; end
        3'h1: begin dx = 2'sd1; dy = -2'sd1; end
        3'h2: begin dx = 2'sd0; dy = -2'sd1; end
        3'h3: begin dx = -2'sd1; dy = -2'sd1; end
        3'h4: begin dx = -2'sd1; dy = 2'sd0; end
        3'h5: begin dx = -2'sd1; dy = 2'sd1; end
        3'h6: begin dx = 2'sd0; dy = 2'sd1; end
        default: begin dx = 2'sd1; dy = 2'sd1; end
      endcase
      horiz = (dy == 2'sd0);
      down = (dy == 2'sd1);
    end else begin
      if (octant[`OCT_MAJOR]) begin // RULE_06 RULE_07
        dy = sy;
        dx = minorStep ? sx : 2'sd0; // RULE_26
      end else begin
        dx = sx;
        dy = minorStep ? sy : 2'sd0; // RULE_26
      end
      // No minor delta on an x-major line means it is horizontal
      horiz = !octant[`OCT_MAJOR] && (k1 == 0);
      down = !octant[`OCT_YSIGN];
    end
  end
endmodule : step_decode

// [bench/line_step_engine_checker.sv]
// Port-level assertions for the line and step-vector draw engine
`timescale 1ns/1ps
`include "line_step_cfg.svh"
module line_step_engine_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic opWrite,
  input wire logic [`FN_W-1:0] opFunction,
  input wire logic stepWrite,
  input wire logic [31:0] stepData,
  input wire logic [3:0] stepByteEn,
  input wire logic [`DIM_W-1:0] dstWidth,
  input wire logic [`DIM_W-1:0] dstHeight,
  input wire logic busy,
  input wire logic pixValid,
  input wire logic pixWrite,
  input wire line_step_pkg::ptr_t pixDstX,
  input wire line_step_pkg::ptr_t pixDstY,
  input wire line_step_pkg::ptr_t srcX,
  input wire line_step_pkg::ptr_t patX
);
  ////////////////////////////////////////////////////////////////////
  // Shadow of the latched function; start requests only count when idle
  logic [`FN_W-1:0] fnReg, fnNext;
  logic opTaken, stepIdle;
  assign opTaken = opWrite && !busy;
  assign stepIdle = stepWrite && !opWrite && !busy;
  always_comb begin
    fnNext = opTaken ? opFunction : fnReg;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fnReg <= '0;
    end else begin
      fnReg <= fnNext;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  property p_write_valid;
    pixWrite |-> pixValid;
  endproperty
  a_write_valid: assert property (p_write_valid)
    else $error("pixel write without pixel valid");
  property p_pixel_in_op;
    pixValid |-> $past(busy);
  endproperty
  a_pixel_in_op: assert property (p_pixel_in_op)
    else $error("pixel outside an operation");
  property p_function_only;
    opTaken && opFunction == `FN_STEP |=> !busy;
  endproperty
  a_function_only: assert property (p_function_only)
    else $error("function select started drawing");
  property p_other_function;
    stepIdle && stepByteEn[3] && fnReg != `FN_STEP |=> !busy[*2];
  endproperty
  a_other_function: assert property (p_other_function)
    else $error("step write ran under another function");
  property p_top_byte_start;
    stepIdle && !stepByteEn[3] |=> !busy;
  endproperty
  a_top_byte_start: assert property (p_top_byte_start)
    else $error("step write without top byte started");
  property p_stop_first;
    stepIdle && stepByteEn == 4'hF && fnReg == `FN_STEP
      && stepData[7:0] == `STOP_CODE |=> busy ##1
      (pixValid && !pixWrite && !busy);
  endproperty
  a_stop_first: assert property (p_stop_first)
    else $error("stop code did not end after one move");
  property p_line_start;
    opTaken && opFunction == `FN_LINE |=> busy ##1 pixValid;
  endproperty
  a_line_start: assert property (p_line_start)
    else $error("line did not start");
  property p_pattern_x;
    busy |=> $changed(patX) == $changed(srcX);
  endproperty
  a_pattern_x: assert property (p_pattern_x)
    else $error("pattern x not stepping with source x");
  property p_scissor;
    pixWrite |-> pixDstX >= 0 && pixDstY >= 0
      && pixDstX < $signed({1'h0, dstWidth})
      && pixDstY < $signed({1'h0, dstHeight});
  endproperty
  a_scissor: assert property (p_scissor)
    else $error("write outside destination map");
endmodule : line_step_engine_checker

// [bench/tb_line_step_engine.sv]
// Self-checking bench for the line and step-vector draw engine
`timescale 1ns/1ps
`include "line_step_cfg.svh"
module tb_line_step_engine;
  logic ref_clk, nrst, opWrite, opReadDraw, stepWrite, ptrLoad;
  logic busy, pixValid, pixWrite;
  logic [`FN_W-1:0] opFunction;
  logic [2:0] opOctant;
  logic [1:0] opDrawMode;
  logic [3:0] stepByteEn;
  logic [31:0] stepData;
  logic [`DIM_W-1:0] opLength, srcWidth, srcHeight, patWidth, patHeight;
  logic [`DIM_W-1:0] dstWidth, dstHeight;
  line_step_pkg::err_t errInit, k1Init, k2Init;
  line_step_pkg::ptr_t srcXInit, srcYInit, patXInit, patYInit;
  line_step_pkg::ptr_t dstXInit, dstYInit, srcX, srcY, patX, patY;
  line_step_pkg::ptr_t dstX, dstY, pixSrcX, pixSrcY, pixPatX, pixPatY;
  line_step_pkg::ptr_t pixDstX, pixDstY, lastSrcX, lastDstX, lastDstY;
  line_step_pkg::ptr_t lastSrcY, lastPatX, lastPatY;
  int mismatches, cmp_count, cycles, nValid, nWrite;
  // Pattern mirrors source so the checker can compare their stepping
  assign patXInit = srcXInit;
  assign patYInit = srcYInit;
  assign patWidth = srcWidth;
  assign patHeight = srcHeight;
  line_step_engine dut (.*);
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string w, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", w, e, s);
    end
  endtask : chk
  // Bounded wait: a hung engine shows up as busy still high
  task automatic collect();
    nValid = 0;
    nWrite = 0;
    for (int n = 0; n < 200; n++) begin
      @(posedge ref_clk);
      #1;
      if (pixValid === 1'h1) begin
        nValid++;
        nWrite += (pixWrite === 1'h1);
        lastSrcX = pixSrcX;
        lastSrcY = pixSrcY;
        lastPatX = pixPatX;
        lastPatY = pixPatY;
        lastDstX = pixDstX;
        lastDstY = pixDstY;
      end
      if (busy !== 1'h1) break;
    end
    chk("busy", busy, 0);
  endtask : collect
  task automatic load(input int sx, sy, dx, dy);
    @(posedge ref_clk);
    ptrLoad <= 1'h1;
    {srcXInit, srcYInit, dstXInit, dstYInit} <= {sx[12:0], sy[12:0],
      dx[12:0], dy[12:0]};
    @(posedge ref_clk);
    ptrLoad <= 1'h0;
  endtask : load
  task automatic op(input logic [2:0] fn, oct, input logic [1:0] md,
    input logic rd, input int len, e, a, b);
    @(posedge ref_clk);
    opWrite <= 1'h1;
    {opFunction, opOctant, opDrawMode, opReadDraw} <= {fn, oct, md, rd};
    {opLength, errInit, k1Init, k2Init} <= {len[11:0], e[15:0], a[15:0],
      b[15:0]};
    @(posedge ref_clk);
    opWrite <= 1'h0;
    collect();
  endtask : op
  task automatic step(input logic [31:0] d, input logic [3:0] en);
    @(posedge ref_clk);
    {stepWrite, stepData, stepByteEn} <= {1'h1, d, en};
    @(posedge ref_clk);
    stepWrite <= 1'h0;
    collect();
  endtask : step
  ////////////////////////////////////////////////////////////////////
  task automatic line_write_sc();
    load(2, 3, 5, 5);
    op(`FN_LINE, 3'h0, `MODE_NORMAL, 1'h0, 1, 1, 2, 0);
    chk("pixels", nValid, 2);
    chk("lastDstX", lastDstX, 6);
    chk("lastDstY", lastDstY, 6);
    chk("dstX", dstX, 6);
    chk("dstY", dstY, 6);
    chk("lastSrcX", lastSrcX, 3);
    chk("srcY", srcY, 3);
  endtask : line_write_sc
  task automatic line_read_sc();
    load(1, 4, 5, 5);
    op(`FN_LINE, 3'h6, `MODE_NORMAL, 1'h1, 2, -2, 0, -4);
    chk("lastSrcX", lastSrcX, 7);
    chk("srcX", srcX, 7);
    chk("srcY", srcY, 4);
    chk("lastDstX", lastDstX, 7);
    chk("dstY", dstY, 5);
    chk("lastSrcY", lastSrcY, 4);
    chk("lastPatX", lastPatX, 7);
    chk("lastPatY", lastPatY, 4);
    chk("patY", patY, 4);
  endtask : line_read_sc
  task automatic step_sc();
    op(`FN_STEP, 3'h0, `MODE_NORMAL, 1'h0, 0, 0, 0, 0);
    chk("idle pixels", nValid, 0);
    load(0, 0, 17, 10);
    step(32'h0000_0035, 4'hF);
    chk("pixels", nValid, 7);
    chk("writes", nWrite, 6);
    chk("dstX", dstX, 22);
    chk("dstY", dstY, 5);
    step(32'h1130_0000, 4'hC);
    chk("upper pixels", nValid, 3);
    chk("dstX", dstX, 23);
    step(32'h3535_3500, 4'hF);
    chk("stop pixels", nValid, 1);
    step(32'h0035_3535, 4'h7);
    chk("no top byte", nValid, 0);
    op(3'h0, 3'h0, `MODE_NORMAL, 1'h0, 0, 0, 0, 0);
    step(32'h1111_1111, 4'hF);
    chk("other function", nValid, 0);
  endtask : step_sc
  task automatic mode_sc();
    int want [4] = '{3, 2, 2, 2};
    for (int m = 0; m < 4; m++) begin
      load(0, 0, 5, 5);
      op(`FN_LINE, 3'h0, m[1:0], 1'h0, 2, 2, 4, 0);
      chk("mode writes", nWrite, want[m]);
    end
    op(`FN_LINE, 3'h0, `MODE_AREA, 1'h0, 2, -2, 0, -4);
    chk("flat writes", nWrite, 0);
    for (int m = 1; m < 3; m++) begin
      op(`FN_STEP, 3'h0, m[1:0], 1'h0, 0, 0, 0, 0);
      load(0, 0, 17, 10);
      step(32'h0000_0035, 4'hF);
      chk("step writes", nWrite, 5);
    end
  endtask : mode_sc
  task automatic scissor_sc();
    load(0, 0, 63, 5);
    op(`FN_LINE, 3'h0, `MODE_NORMAL, 1'h0, 1, -1, 0, -2);
    chk("edge writes", nWrite, 1);
    chk("dstX", dstX, 64);
  endtask : scissor_sc
  // Upward outline keeps run starts; left-clipped outline still marks x=0
  task automatic area_sc();
    load(0, 0, 5, 10);
    op(`FN_LINE, 3'h2, `MODE_AREA, 1'h0, 2, 0, 2, -2);
    chk("up writes", nWrite, 1);
    chk("up dstY", dstY, 9);
    load(0, 0, -3, 5);
    op(`FN_LINE, 3'h0, `MODE_AREA, 1'h0, 1, 1, 2, 0);
    chk("clip writes", nWrite, 1);
    chk("clip dstX", dstX, -2);
  endtask : area_sc
  initial begin
    nrst = 1'h0;
    {opWrite, stepWrite, ptrLoad, opReadDraw} = 4'h0;
    {opFunction, opOctant, opDrawMode, stepByteEn} = 12'h000;
    {opLength, errInit, k1Init, k2Init, stepData} = '0;
    {srcXInit, srcYInit, dstXInit, dstYInit} = '0;
    srcWidth = 12'h008;
    srcHeight = 12'h040;
    dstWidth = 12'h040;
    dstHeight = 12'h040;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    line_write_sc();
    line_read_sc();
    step_sc();
    mode_sc();
    scissor_sc();
    area_sc();
    end_of_test();
  end
endmodule : tb_line_step_engine
bind line_step_engine line_step_engine_checker u_checker (.*);
